// ==== core/scr_pkg.sv ====
// Shared constants, types and helpers of the system clock, reset and power control block
package scr_pkg;

  // Register offsets (byte addresses, one 32-bit word each)
  localparam logic [7:0] SCR_PLL_CTRL_OFS  = 8'h00;
  localparam logic [7:0] SCR_PLL_CFG_OFS   = 8'h04;
  localparam logic [7:0] SCR_PLL_STAT_OFS  = 8'h08;
  localparam logic [7:0] SCR_PWR_CTRL_OFS  = 8'h0c;
  localparam logic [7:0] SCR_PERIPH_OFS    = 8'h10;
  localparam logic [7:0] SCR_PCLK_DIV_OFS  = 8'h14;
  localparam logic [7:0] SCR_MEMMAP_OFS    = 8'h18;
  localparam logic [7:0] SCR_EXT_MODE_OFS  = 8'h1c;
  localparam logic [7:0] SCR_EXT_FLAG_OFS  = 8'h20;
  localparam logic [7:0] SCR_EXT_WAKE_OFS  = 8'h24;
  localparam logic [7:0] SCR_EXT_PEN_OFS   = 8'h28;
  localparam logic [7:0] SCR_EXT_ROUTE_OFS = 8'h2c;
  localparam logic [7:0] SCR_RST_STAT_OFS  = 8'h30;

  // Field positions
  localparam int SCR_PLL_EN_BIT    = 0;
  localparam int SCR_PLL_CONN_BIT  = 1;
  localparam int SCR_CFG_DIV_LSB   = 5;
  localparam int SCR_PWR_IDLE_BIT  = 0;
  localparam int SCR_PWR_PD_BIT    = 1;
  localparam int SCR_EXT_POL_LSB   = 4;
  localparam int SCR_STAT_EN_BIT   = 8;
  localparam int SCR_STAT_LOCK_BIT = 10;
  localparam int SCR_STAT_SEL_BIT  = 11;
  localparam int SCR_STAT_OK_BIT   = 12;
  localparam int SCR_PWR_STATE_LSB = 8;

  // Sizes and reset values
  localparam int               SCR_EXT_PINS     = 9;
  localparam int               SCR_EXT_LINES    = 4;
  localparam int               SCR_PERIPHS      = 16;
  localparam logic [15:0]      SCR_PERIPH_RST   = 16'hffff;
  localparam logic [1:0]       SCR_PCLK_DIV_RST = 2'h0;
  localparam logic             SCR_MEMMAP_RST   = 1'b0;
  localparam logic [31:0]      SCR_RESET_VECTOR = 32'h0000_0000;

  // Frequency limits in MHz, and the largest multiplier
  localparam int SCR_PLL_IN_MIN  = 10;
  localparam int SCR_PLL_IN_MAX  = 25;
  localparam int SCR_PLL_OUT_MIN = 10;
  localparam int SCR_PLL_OUT_MAX = 60;
  localparam int SCR_LOOP_MIN    = 156;
  localparam int SCR_LOOP_MAX    = 320;
  localparam int SCR_MULT_SW_MAX = 6;

  // Timing
  localparam int SCR_CLK_PERIOD_NS = 10;
  localparam int SCR_GLITCH_NS     = 50;
  localparam int SCR_GLITCH_CYC    = (SCR_GLITCH_NS + SCR_CLK_PERIOD_NS - 1) / SCR_CLK_PERIOD_NS;
  localparam int SCR_WAKE_CYC      = 4096;
  localparam int SCR_SWITCH_GAP    = 4;

  typedef enum logic [1:0] {
    SCR_PCLK_QUARTER = 2'h0,
    SCR_PCLK_FULL    = 2'h1,
    SCR_PCLK_HALF    = 2'h2
  } scr_pclk_e;

  typedef enum logic [6:0] {
    SCR_ST_RESET = 7'h01,
    SCR_ST_OSC   = 7'h02,
    SCR_ST_COUNT = 7'h04,
    SCR_ST_FLASH = 7'h08,
    SCR_ST_RUN   = 7'h10,
    SCR_ST_IDLE  = 7'h20,
    SCR_ST_PDOWN = 7'h40
  } scr_state_e;

  // Multiplier is stored minus one; divider code p gives divide by 2 << p
  typedef struct packed {
    logic [1:0] div_p;
    logic [4:0] mult_m1;
  } scr_pll_cfg_s;

  function automatic logic scr_pll_ok(input int osc_mhz, input scr_pll_cfg_s cfg);
    int mult;
    int fout;
    int floop;
    mult = int'(cfg.mult_m1) + 1;
    fout = osc_mhz * mult;
    floop = fout * (2 << cfg.div_p);
    return (osc_mhz >= SCR_PLL_IN_MIN) && (osc_mhz <= SCR_PLL_IN_MAX) &&
           (fout >= SCR_PLL_OUT_MIN) && (fout <= SCR_PLL_OUT_MAX) &&
           (floop >= SCR_LOOP_MIN) && (floop <= SCR_LOOP_MAX) && (mult <= SCR_MULT_SW_MAX);
  endfunction : scr_pll_ok

  function automatic logic [31:0] scr_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : scr_merge

endpackage : scr_pkg

// ==== core/scr_pin_filter.sv ====
// Two-stage synchroniser and glitch filter for the external reset pin
`timescale 1ns/100ps
module scr_pin_filter
  import scr_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic pin_i,
  output logic      level_o
);

  logic       sync1_r;
  logic       sync2_r;
  logic       level_r;
  logic [3:0] stable_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else if (ce_i) begin
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
    end
  end

  // Level only follows after it has stood unchanged for the whole filter window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_r  <= 1'b0;
      stable_r <= 4'h0;
    end else if (ce_i) begin
      if (sync2_r == level_r) begin
        stable_r <= 4'h0;
      end else if (stable_r == 4'(SCR_GLITCH_CYC - 1)) begin
        level_r  <= sync2_r;
        stable_r <= 4'h0;
      end else begin
        stable_r <= stable_r + 4'h1;
      end
    end
  end

  assign level_o = level_r;

endmodule : scr_pin_filter

// ==== core/scr_sysctl.sv ====
// System clock, reset sequencing and power control with a Wishbone register slave
`timescale 1ns/100ps
module scr_sysctl
  import scr_pkg::*;
#(
  parameter int OSC_MHZ = 12
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  input  wire logic                     reset_pin_n_i,
  input  wire logic                     wdt_rst_i,
  input  wire logic                     osc_ok_i,
  input  wire logic                     flash_done_i,
  input  wire logic                     irq_i,
  input  wire logic [SCR_EXT_PINS-1:0]  ext_pin_i,
  input  wire logic                     pll_lock_i,
  output logic                          sys_rst_o,
  output logic      [31:0]              reset_vector_o,
  output logic                          flash_init_o,
  output logic                          osc_en_o,
  output logic                          pll_run_o,
  output scr_pll_cfg_s                  pll_cfg_o,
  output logic                          cclk_sel_pll_o,
  output logic                          cclk_gate_o,
  output logic                          cpu_run_o,
  output logic                          pclk_en_o,
  output logic      [SCR_PERIPHS-1:0]   periph_pwr_o,
  output logic                          vec_ram_o,
  output logic      [SCR_EXT_LINES-1:0] ext_irq_o
);

  scr_state_e                   state_r;
  scr_pll_cfg_s                 pll_cfg_r;
  logic                         pll_en_r;
  logic                         pll_conn_r;
  logic                         idle_req_r;
  logic                         pd_req_r;
  logic [SCR_PERIPHS-1:0]       periph_r;
  logic [1:0]                   pclk_div_r;
  logic                         memmap_r;
  logic [7:0]                   ext_mode_r;
  logic [SCR_EXT_LINES-1:0]     ext_flag_r;
  logic [SCR_EXT_LINES-1:0]     ext_wake_r;
  logic [SCR_EXT_PINS-1:0]      ext_pen_r;
  logic [2*SCR_EXT_PINS-1:0]    ext_route_r;
  logic [SCR_EXT_LINES-1:0]     ext_line_prev_r;
  logic [1:0]                   rst_stat_r;
  logic [12:0]                  wake_cnt_r;
  logic                         from_pd_r;
  logic                         sys_rst_r;
  logic                         cur_sel_r;
  logic                         gate_r;
  logic [2:0]                   gap_cnt_r;
  logic [1:0]                   pclk_cnt_r;
  logic                         ack_r;
  logic [31:0]                  rdata_r;
  logic [SCR_EXT_PINS-1:0]      ext_s1_r;
  logic [SCR_EXT_PINS-1:0]      ext_s2_r;
  logic                         lock_s1_r;
  logic                         lock_s2_r;
  logic                         osc_s1_r;
  logic                         osc_s2_r;
  logic                         pin_level;
  logic                         chip_rst;
  logic                         reg_rst;
  logic                         wr_stb;
  logic [31:0]                  wdata;
  logic [7:0]                   w1c_data;
  logic [31:0]                  rd_nxt;
  logic [SCR_EXT_LINES-1:0]     line_lvl;
  logic [SCR_EXT_LINES-1:0]     line_evt;
  logic                         want_pll;
  logic                         wake_evt;
  logic                         pclk_tick;

  scr_pin_filter u_pin_filter (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .pin_i   (reset_pin_n_i),
    .level_o (pin_level)
  );

  assign chip_rst = ~pin_level | wdt_rst_i;
  assign reg_rst  = rst_i | chip_rst;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_s1_r  <= '0;
      ext_s2_r  <= '0;
      lock_s1_r <= 1'b0;
      lock_s2_r <= 1'b0;
      osc_s1_r  <= 1'b0;
      osc_s2_r  <= 1'b0;
    end else if (ce_i) begin
      ext_s1_r  <= ext_pin_i;
      ext_s2_r  <= ext_s1_r;
      lock_s1_r <= pll_lock_i;
      lock_s2_r <= lock_s1_r;
      osc_s1_r  <= osc_ok_i;
      osc_s2_r  <= osc_s1_r;
    end
  end

  // Wishbone slave: one wait state, ack for one cycle, unmapped reads zero
  assign wr_stb   = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  always_comb begin
    rd_nxt = 32'h0;
    case (wb_adr_i)
      SCR_PLL_CTRL_OFS:  rd_nxt = {30'h0, pll_conn_r, pll_en_r};
      SCR_PLL_CFG_OFS:   rd_nxt = {25'h0, pll_cfg_r};
      SCR_PLL_STAT_OFS:  begin
        rd_nxt = {25'h0, pll_cfg_r};
        rd_nxt[SCR_STAT_EN_BIT]     = pll_en_r;
        rd_nxt[SCR_STAT_EN_BIT + 1] = pll_conn_r;
        rd_nxt[SCR_STAT_LOCK_BIT]   = lock_s2_r;
        rd_nxt[SCR_STAT_SEL_BIT]    = cur_sel_r;
        rd_nxt[SCR_STAT_OK_BIT]     = scr_pll_ok(OSC_MHZ, pll_cfg_r);
      end
      SCR_PWR_CTRL_OFS:  begin
        rd_nxt = {30'h0, pd_req_r, idle_req_r};
        rd_nxt[SCR_PWR_STATE_LSB +: 7] = state_r;
      end
      SCR_PERIPH_OFS:    rd_nxt = {16'h0, periph_r};
      SCR_PCLK_DIV_OFS:  rd_nxt = {30'h0, pclk_div_r};
      SCR_MEMMAP_OFS:    rd_nxt = {31'h0, memmap_r};
      SCR_EXT_MODE_OFS:  rd_nxt = {24'h0, ext_mode_r};
      SCR_EXT_FLAG_OFS:  rd_nxt = {28'h0, ext_flag_r};
      SCR_EXT_WAKE_OFS:  rd_nxt = {28'h0, ext_wake_r};
      SCR_EXT_PEN_OFS:   rd_nxt = {23'h0, ext_pen_r};
      SCR_EXT_ROUTE_OFS: rd_nxt = {14'h0, ext_route_r};
      SCR_RST_STAT_OFS:  rd_nxt = {30'h0, rst_stat_r};
      default:           rd_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0;
    end else if (ce_i) begin
      ack_r   <= wb_cyc_i & wb_stb_i & ~ack_r;
      if (wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_r) begin
        rdata_r <= rd_nxt;
      end
    end
  end

  assign wdata = scr_merge(rd_nxt, wb_dat_i, wb_sel_i);
  // Clear masks must not merge in the live flags of unselected lanes
  assign w1c_data = wb_dat_i[7:0] & {8{wb_sel_i[0]}};

  // PLL off and bypassed after any chip reset
  always_ff @(posedge clk_i) begin
    if (reg_rst) begin
      pll_en_r   <= 1'b0;
      pll_conn_r <= 1'b0;
      pll_cfg_r  <= '0;
    end else if (ce_i && wr_stb) begin
      if (wb_adr_i == SCR_PLL_CTRL_OFS) begin
        pll_en_r   <= wdata[SCR_PLL_EN_BIT];
        pll_conn_r <= wdata[SCR_PLL_CONN_BIT];
      end
      if (wb_adr_i == SCR_PLL_CFG_OFS) begin
        pll_cfg_r.mult_m1 <= wdata[4:0];
        // Divide 2, 4, 8 or 16
        pll_cfg_r.div_p   <= wdata[SCR_CFG_DIV_LSB +: 2];
      end
    end
  end

  // Mode requests clear themselves once the mode is left
  always_ff @(posedge clk_i) begin
    if (reg_rst) begin
      idle_req_r <= 1'b0;
      pd_req_r   <= 1'b0;
    end else if (ce_i) begin
      if (wr_stb && wb_adr_i == SCR_PWR_CTRL_OFS) begin
        idle_req_r <= wdata[SCR_PWR_IDLE_BIT];
        pd_req_r   <= wdata[SCR_PWR_PD_BIT];
      end else begin
        if (state_r == SCR_ST_IDLE && (irq_i || ext_flag_r != '0)) begin
          idle_req_r <= 1'b0;
        end
        if (state_r == SCR_ST_PDOWN && wake_evt) begin
          pd_req_r <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reg_rst) begin
      periph_r    <= SCR_PERIPH_RST;
      pclk_div_r  <= SCR_PCLK_DIV_RST;
      memmap_r    <= SCR_MEMMAP_RST;
      ext_mode_r  <= '0;
      ext_wake_r  <= '0;
      ext_pen_r   <= '0;
      ext_route_r <= '0;
    end else if (ce_i && wr_stb) begin
      case (wb_adr_i)
        SCR_PERIPH_OFS:    periph_r    <= wdata[SCR_PERIPHS-1:0];
        SCR_PCLK_DIV_OFS:  pclk_div_r  <= wdata[1:0];
        SCR_MEMMAP_OFS:    memmap_r    <= wdata[0];
        SCR_EXT_MODE_OFS:  ext_mode_r  <= wdata[7:0];
        SCR_EXT_WAKE_OFS:  ext_wake_r  <= wdata[SCR_EXT_LINES-1:0];
        SCR_EXT_PEN_OFS:   ext_pen_r   <= wdata[SCR_EXT_PINS-1:0];
        SCR_EXT_ROUTE_OFS: ext_route_r <= wdata[2*SCR_EXT_PINS-1:0];
        default:           ;
      endcase
    end
  end

  // Route nine pins onto four lines, with polarity
  always_comb begin
    line_lvl = '0;
    for (int p = 0; p < SCR_EXT_PINS; p++) begin
      if (ext_pen_r[p] && ext_s2_r[p]) begin
        line_lvl[ext_route_r[2*p +: 2]] = 1'b1;
      end
    end
    line_lvl = line_lvl ^ ~ext_mode_r[SCR_EXT_POL_LSB +: SCR_EXT_LINES];
  end

  // Edge mode flags on rising active edge, level mode while active
  assign line_evt = (ext_mode_r[SCR_EXT_LINES-1:0] & line_lvl & ~ext_line_prev_r) |
                    (~ext_mode_r[SCR_EXT_LINES-1:0] & line_lvl);

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (reg_rst) begin
      ext_flag_r      <= '0;
      ext_line_prev_r <= '0;
    end else if (ce_i) begin
      ext_line_prev_r <= line_lvl;
      if (wr_stb && wb_adr_i == SCR_EXT_FLAG_OFS) begin
        ext_flag_r <= (ext_flag_r & ~w1c_data[SCR_EXT_LINES-1:0]) | line_evt;
      end else begin
        ext_flag_r <= ext_flag_r | line_evt;
      end
    end
  end

  // Reset cause survives chip reset; only power-on reset or a write-one clear clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_stat_r <= 2'h0;
    end else if (ce_i) begin
      if (wr_stb && wb_adr_i == SCR_RST_STAT_OFS) begin
        rst_stat_r <= (rst_stat_r & ~w1c_data[1:0]) | {wdt_rst_i, ~pin_level};
      end else begin
        rst_stat_r <= rst_stat_r | {wdt_rst_i, ~pin_level};
      end
    end
  end

  // Only an enabled external line or a chip reset ends power-down
  assign wake_evt = (ext_flag_r & ext_wake_r) != '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r    <= SCR_ST_RESET;
      wake_cnt_r <= 13'h0;
      from_pd_r  <= 1'b0;
    end else if (ce_i) begin
      if (chip_rst) begin
        // Any reset restarts the wake-up timer
        state_r    <= SCR_ST_RESET;
        wake_cnt_r <= 13'h0;
        from_pd_r  <= 1'b0;
      end else begin
        case (state_r)
          SCR_ST_RESET: state_r <= SCR_ST_OSC;
          SCR_ST_OSC: begin
            wake_cnt_r <= 13'h0;
            if (osc_s2_r) begin
              state_r <= SCR_ST_COUNT;
            end
          end
          SCR_ST_COUNT: begin
            wake_cnt_r <= wake_cnt_r + 13'h1;
            if (wake_cnt_r == 13'(SCR_WAKE_CYC - 1)) begin
              state_r <= from_pd_r ? SCR_ST_RUN : SCR_ST_FLASH;
            end
          end
          SCR_ST_FLASH: if (flash_done_i) begin
            state_r <= SCR_ST_RUN;
          end
          SCR_ST_RUN: begin
            from_pd_r <= 1'b0;
            if (pd_req_r) begin
              state_r <= SCR_ST_PDOWN;
            end else if (idle_req_r) begin
              state_r <= SCR_ST_IDLE;
            end
          end
          SCR_ST_IDLE: if (irq_i || ext_flag_r != '0) begin
            state_r <= SCR_ST_RUN;
          end
          SCR_ST_PDOWN: if (wake_evt) begin
            state_r   <= SCR_ST_OSC;
            from_pd_r <= 1'b1;
          end
          default: state_r <= SCR_ST_RESET;
        endcase
      end
    end
  end

  // Wake from power-down keeps state, so it holds the processor without resetting it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_rst_r <= 1'b1;
    end else if (ce_i) begin
      sys_rst_r <= chip_rst || state_r == SCR_ST_RESET || state_r == SCR_ST_FLASH ||
                   ((state_r == SCR_ST_OSC || state_r == SCR_ST_COUNT) && !from_pd_r);
    end
  end

  // PLL only when enabled, connected and locked
  assign want_pll = pll_en_r & pll_conn_r & lock_s2_r & (state_r != SCR_ST_PDOWN);

  // Gate off, switch, then gate on
  always_ff @(posedge clk_i) begin
    if (reg_rst) begin
      cur_sel_r <= 1'b0;
      gate_r    <= 1'b1;
      gap_cnt_r <= 3'h0;
    end else if (ce_i) begin
      if (gate_r) begin
        gap_cnt_r <= 3'h0;
        if (want_pll != cur_sel_r) begin
          gate_r <= 1'b0;
        end
      end else if (gap_cnt_r == 3'(SCR_SWITCH_GAP - 1)) begin
        gap_cnt_r <= 3'h0;
        if (want_pll != cur_sel_r) begin
          cur_sel_r <= want_pll;
        end else begin
          gate_r <= 1'b1;
        end
      end else begin
        gap_cnt_r <= gap_cnt_r + 3'h1;
      end
    end
  end

  // Peripheral clock tick at full, half or quarter rate
  always_comb begin
    case (pclk_div_r)
      SCR_PCLK_FULL: pclk_tick = 1'b1;
      SCR_PCLK_HALF: pclk_tick = pclk_cnt_r[0];
      default:       pclk_tick = pclk_cnt_r == 2'h3;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reg_rst) begin
      pclk_cnt_r <= 2'h0;
      pclk_en_o  <= 1'b0;
    end else if (ce_i) begin
      if (state_r == SCR_ST_PDOWN || !gate_r) begin
        pclk_en_o <= 1'b0;
      end else begin
        pclk_cnt_r <= pclk_cnt_r + 2'h1;
        pclk_en_o  <= pclk_tick;
      end
    end
  end

  assign sys_rst_o      = sys_rst_r;
  assign reset_vector_o = SCR_RESET_VECTOR;
  assign flash_init_o   = state_r == SCR_ST_FLASH;
  assign osc_en_o       = state_r != SCR_ST_PDOWN;
  assign pll_run_o      = pll_en_r & (state_r != SCR_ST_PDOWN);
  // Loop settings driven to the analog PLL
  assign pll_cfg_o      = pll_cfg_r;
  assign cclk_sel_pll_o = cur_sel_r;
  assign cclk_gate_o    = gate_r & (state_r != SCR_ST_PDOWN);
  assign cpu_run_o      = ~sys_rst_r & (state_r == SCR_ST_RUN) & gate_r;
  // Peripheral power straight from the register in every state, held while clocks are stopped
  assign periph_pwr_o   = periph_r;
  assign vec_ram_o      = memmap_r;
  assign ext_irq_o      = ext_flag_r;

endmodule : scr_sysctl

// ==== dv/scr_far_model.sv ====
// Far-side model: oscillator start-up, PLL lock and flash init
`timescale 1ns/100ps
module scr_far_model #(
  parameter int OSC_DLY  = 20,
  parameter int LOCK_DLY = 30
) (
  input  wire logic clk_i,
  input  wire logic osc_en_i,
  input  wire logic pll_run_i,
  input  wire logic flash_init_i,
  output logic      osc_ok_o,
  output logic      pll_lock_o,
  output logic      flash_done_o
);
  int   osc_cnt = 0;
  int   lock_cnt = 0;
  logic fl_r = 1'h0;
  always_ff @(posedge clk_i) begin
    osc_cnt <= osc_en_i ? osc_cnt + int'(osc_cnt < OSC_DLY) : 0;
    lock_cnt <= (pll_run_i && osc_ok_o) ? lock_cnt + int'(lock_cnt < LOCK_DLY) : 0;
    fl_r <= flash_init_i;
  end
  assign osc_ok_o = osc_cnt == OSC_DLY;
  assign pll_lock_o = lock_cnt == LOCK_DLY;
  assign flash_done_o = fl_r;
endmodule : scr_far_model

// ==== dv/scr_sysctl_sva.sv ====
// Port-level checker of the system control block
`timescale 1ns/100ps
module scr_sysctl_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wdt_rst_i,
  input wire logic        sys_rst_o,
  input wire logic        flash_init_o,
  input wire logic        osc_en_o,
  input wire logic        pll_run_o,
  input wire logic        cclk_sel_pll_o,
  input wire logic        cclk_gate_o,
  input wire logic        cpu_run_o,
  input wire logic        pclk_en_o,
  input wire logic [15:0] periph_pwr_o,
  input wire logic        vec_ram_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_pll_rst; sys_rst_o |-> !pll_run_o && !cclk_sel_pll_o; endproperty
  a_pll_rst: assert property (p_pll_rst) else $error("PLL active in reset");
  property p_flash; flash_init_o |-> sys_rst_o; endproperty
  a_flash: assert property (p_flash) else $error("reset off during flash init");
  property p_wdt; $rose(wdt_rst_i) |-> ##[1:3] sys_rst_o; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog gave no reset");
  property p_run; cpu_run_o |-> !sys_rst_o && cclk_gate_o && osc_en_o; endproperty
  a_run: assert property (p_run) else $error("execution while unsafe");
  property p_wake; $rose(osc_en_o) |-> !cpu_run_o [*8]; endproperty
  a_wake: assert property (p_wake) else $error("wake skipped timer");
  property p_pd;
    !osc_en_o && !$past(osc_en_o) |-> !cclk_gate_o && !pclk_en_o && !pll_run_o
      && $stable(periph_pwr_o) && $stable(vec_ram_o);
  endproperty
  a_pd: assert property (p_pd) else $error("activity in power-down");
  property p_pclk;
    pclk_en_o |-> ##[1:4] (pclk_en_o || !osc_en_o || !cclk_gate_o || sys_rst_o);
  endproperty
  a_pclk: assert property (p_pclk) else $error("peripheral tick too slow");
  property p_switch;
    $changed(cclk_sel_pll_o) && !sys_rst_o |-> !cclk_gate_o ##1 !cclk_gate_o [*3];
  endproperty
  a_switch: assert property (p_switch) else $error("clock switched ungated");
  c_pd: cover property ($fell(osc_en_o));
  c_sw: cover property ($rose(cclk_sel_pll_o));
  c_wdt: cover property ($rose(wdt_rst_i) ##[1:3] sys_rst_o);
endmodule : scr_sysctl_chk
bind scr_sysctl scr_sysctl_chk u_chk (.*);

// ==== dv/system_clock_reset_power_control_test.sv ====
// Self-checking bench of the system control block
`timescale 1ns/100ps
module system_clock_reset_power_control_test
  import scr_pkg::*;
;
  logic         clk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1, wb_cyc_i = 1'h0, wb_we_i = 1'h0;
  logic         reset_pin_n_i = 1'h1, wdt_rst_i = 1'h0, irq_i = 1'h0;
  logic [7:0]   wb_adr_i = 8'h00;
  logic [3:0]   wb_sel_i = 4'h0;
  logic [31:0]  wb_dat_i = 32'h0, rd, wb_dat_o, reset_vector_o;
  logic [8:0]   ext_pin_i = 9'h000;
  logic         osc_ok_i, pll_lock_i, flash_done_i, wb_ack_o, sys_rst_o, flash_init_o;
  logic         osc_en_o, pll_run_o, cclk_sel_pll_o, cclk_gate_o, cpu_run_o, pclk_en_o;
  logic         vec_ram_o;
  logic [15:0]  periph_pwr_o;
  logic [3:0]   ext_irq_o;
  scr_pll_cfg_s pll_cfg_o;
  wire          wb_stb_i = wb_cyc_i;
  int           err_count = 0, n_compared = 0, n;
  always #5 clk_i = ~clk_i;
  scr_sysctl u_dut (.*);
  scr_far_model u_far (
    .clk_i       (clk_i),
    .osc_en_i    (osc_en_o),
    .pll_run_i   (pll_run_o),
    .flash_init_i(flash_init_o),
    .osc_ok_o    (osc_ok_i),
    .pll_lock_o  (pll_lock_i),
    .flash_done_o(flash_done_i)
  );
  task automatic conclude;
    if (err_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // Held until the rising edge that samples ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    wb_cyc_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    @(posedge clk_i);
  endtask : wb
  function automatic logic cond(input int k);
    case (k)
      0: return !sys_rst_o;
      1: return cpu_run_o;
      default: return cclk_sel_pll_o;
    endcase
  endfunction : cond
  task automatic till(input int k);
    for (n = 0; n < 9000 && cond(k) !== 1'h1; n++) @(posedge clk_i);
    if (n == 9000) err_count++;
  endtask : till
  task automatic t_rst(input logic pin);
    wb(1'h1, SCR_RST_STAT_OFS, 32'h3, 4'hf);
    if (pin) reset_pin_n_i <= 1'h0;
    else wdt_rst_i <= 1'h1;
    repeat (10) @(posedge clk_i);
    reset_pin_n_i <= 1'h1;
    wdt_rst_i <= 1'h0;
    chk(sys_rst_o, 1'h1);
    till(0);
    chk(n >= SCR_WAKE_CYC, 1'h1);
    chk(pll_run_o | cclk_sel_pll_o, 1'h0);
    wb(1'h0, SCR_RST_STAT_OFS, 32'h0, 4'hf);
    chk(rd[1:0], pin ? 2'h1 : 2'h2);
  endtask : t_rst
  task automatic t_regs;
    wb(1'h0, SCR_PLL_STAT_OFS, 32'h0, 4'hf);
    chk(rd[9:8], 2'h0);
    chk(cclk_sel_pll_o, 1'h0);
    chk(reset_vector_o, SCR_RESET_VECTOR);
    wb(1'h0, SCR_PERIPH_OFS, 32'h0, 4'hf);
    chk(rd, 32'hffff);
    wb(1'h0, SCR_MEMMAP_OFS, 32'h0, 4'hf);
    chk(rd, 32'h0);
    wb(1'h0, 8'h3c, 32'h0, 4'hf);
    chk(rd, 32'h0);
    wb(1'h1, SCR_PERIPH_OFS, 32'h1234_00f0, 4'h1);
    chk(periph_pwr_o, 16'hfff0);
    wb(1'h1, SCR_MEMMAP_OFS, 32'h1, 4'hf);
    chk(vec_ram_o, 1'h1);
  endtask : t_regs
  task automatic t_pclk;
    int k;
    for (int i = 0; i < 4; i++) begin
      wb(1'h1, SCR_PCLK_DIV_OFS, i, 4'hf);
      k = 0;
      repeat (16) begin
        @(posedge clk_i);
        k += int'(pclk_en_o === 1'h1);
      end
      chk(k, i == 1 ? 16 : i == 2 ? 8 : 4);
    end
  endtask : t_pclk
  task automatic t_pll;
    wb(1'h1, SCR_PLL_CFG_OFS, 32'h26, 4'hf);
    wb(1'h0, SCR_PLL_STAT_OFS, 32'h0, 4'hf);
    chk(rd[SCR_STAT_OK_BIT], 1'h0);
    wb(1'h1, SCR_PLL_CFG_OFS, 32'h25, 4'hf);
    wb(1'h0, SCR_PLL_STAT_OFS, 32'h0, 4'hf);
    chk(rd[SCR_STAT_OK_BIT], 1'h0);
    wb(1'h1, SCR_PLL_CFG_OFS, 32'h04, 4'hf);
    wb(1'h0, SCR_PLL_STAT_OFS, 32'h0, 4'hf);
    chk(rd[SCR_STAT_OK_BIT], 1'h0);
    // Five times 12 MHz, oscillator at 240 MHz
    wb(1'h1, SCR_PLL_CFG_OFS, 32'h24, 4'hf);
    chk(pll_cfg_o, 7'h24);
    wb(1'h1, SCR_PLL_CTRL_OFS, 32'h1, 4'hf);
    chk(pll_run_o, 1'h1);
    for (int i = 0; i < 100 && rd[SCR_STAT_LOCK_BIT] !== 1'h1; i++)
      wb(1'h0, SCR_PLL_STAT_OFS, 32'h0, 4'hf);
    chk(rd[SCR_STAT_LOCK_BIT], 1'h1);
    chk(rd[SCR_STAT_OK_BIT], 1'h1);
    chk(cclk_sel_pll_o, 1'h0);
    wb(1'h1, SCR_PLL_CTRL_OFS, 32'h3, 4'hf);
    till(2);
    chk(n < 20, 1'h1);
  endtask : t_pll
  task automatic t_low;
    // Low-active level lines with no pin would end idle at once
    wb(1'h1, SCR_EXT_MODE_OFS, 32'hf1, 4'hf);
    wb(1'h1, SCR_EXT_PEN_OFS, 32'h1, 4'hf);
    wb(1'h1, SCR_EXT_WAKE_OFS, 32'h1, 4'hf);
    wb(1'h1, SCR_EXT_FLAG_OFS, 32'hf, 4'hf);
    chk(ext_irq_o, 4'h0);
    wb(1'h1, SCR_PWR_CTRL_OFS, 32'h1, 4'hf);
    chk(cpu_run_o, 1'h0);
    chk(pll_run_o, 1'h1);
    repeat (4) @(posedge clk_i);
    chk(cpu_run_o, 1'h0);
    irq_i <= 1'h1;
    @(posedge clk_i);
    irq_i <= 1'h0;
    till(1);
    chk(n < 10, 1'h1);
    wb(1'h1, SCR_PWR_CTRL_OFS, 32'h2, 4'hf);
    chk(osc_en_o, 1'h0);
    ext_pin_i <= 9'h001;
    till(1);
    chk(n >= SCR_WAKE_CYC, 1'h1);
    chk(sys_rst_o, 1'h0);
    chk(periph_pwr_o, 16'hfff0);
    chk(ext_irq_o[0], 1'h1);
  endtask : t_low
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    till(0);
    chk(n >= SCR_WAKE_CYC, 1'h1);
    t_regs();
    t_rst(1'h0);
    t_rst(1'h1);
    t_regs();
    t_pclk();
    t_pll();
    t_low();
    t_rst(1'h0);
    conclude();
  end
  initial begin
    #400000;
    err_count++;
    conclude();
  end
endmodule : system_clock_reset_power_control_test
